// ==== hdl/tps_params.svh ====
// Constants for the compensated-oscillator power sequencing block
`ifndef TPS_PARAMS_SVH
`define TPS_PARAMS_SVH
`define TPS_CLK_MHZ        200
`define TPS_OSC_HZ         32768
`define TPS_REC_MS         250
`define TPS_WARM_S         2
`define TPS_CONV_S         64
`define TPS_SEC_W          6
`define TPS_AGE_W          8
`define TPS_CAP_W          8
`define TPS_TEMP_W         10
`define TPS_CAP_MAX        8'hFF
`define TPS_ADDR_CTRL      8'h00
`define TPS_ADDR_AGING     8'h04
`define TPS_ADDR_STATUS    8'h08
`define TPS_ADDR_TEMP      8'h0C
`define TPS_ADDR_CAP       8'h10
`define TPS_CTRL_STOP      0
`define TPS_CTRL_INTSEL    1
`define TPS_CTRL_CONV      2
`define TPS_CTRL_REFEN     3
`define TPS_CTRL_RESET     4'h2
`define TPS_INIT_MONTH     8'h01
`define TPS_INIT_DATE      8'h01
`define TPS_INIT_YEAR      8'h00
`define TPS_INIT_DAY       8'h01
`define TPS_INIT_HMS       24'h000000
`endif

// ==== hdl/tps_pkg.sv ====
// Types for the compensated-oscillator power sequencing block
package tps_pkg;
    typedef enum logic [1:0] {
        TPS_OSC_WAIT,
        TPS_OSC_WARM,
        TPS_OSC_RUN
    } tps_osc_state_t;
    typedef enum logic [0:0] {
        TPS_CV_IDLE,
        TPS_CV_BUSY
    } tps_conv_state_t;
endpackage

// ==== hdl/tps_top.sv ====
// Compensated-oscillator control, supply selection and power-up sequencing
`timescale 1ns/100ps
`include "tps_params.svh"

module tps_top
    import tps_pkg::*;
#(
    parameter int OSC_HZ      = `TPS_OSC_HZ,
    parameter int REC_CYC     = `TPS_REC_MS * `TPS_CLK_MHZ * 1000,
    parameter int PB_HOLD_CYC = `TPS_REC_MS * `TPS_CLK_MHZ * 1000
) (
    input  wire logic                   hclk,
    input  wire logic                   hresetn,
    input  wire logic                   hsel,
    input  wire logic [7:0]             haddr,
    input  wire logic [1:0]             htrans,
    input  wire logic                   hwrite,
    input  wire logic [2:0]             hsize,
    input  wire logic [31:0]            hwdata,
    input  wire logic                   hready,
    output logic      [31:0]            hrdata,
    output logic                        hreadyout,
    output logic                        hresp,
    input  wire logic                   osc_clk_in,
    input  wire logic                   vcc_above_pf_in,
    input  wire logic                   vcc_above_bat_in,
    input  wire logic                   bat_valid_in,
    input  wire logic                   rst_pin_in,
    input  wire logic                   addr_write_ok,
    input  wire logic                   temp_valid,
    input  wire logic [`TPS_TEMP_W-1:0] temp_data,
    input  wire logic                   alarm_req,
    input  wire logic                   square_wave,
    output logic                        conv_start,
    output logic                        osc_enable,
    output logic                        on_backup,
    output logic [`TPS_CAP_W-1:0]       cap_sel,
    output logic                        time_date_load,
    output logic [55:0]                 time_date_init,
    output logic                        rst_pin_oe,
    output logic                        rst_pin_out,
    output logic                        alarm_or_square_wave_oe,
    output logic                        reference_clock_oe
);
    localparam int NSYNC = 5;
    localparam logic [`TPS_CAP_W-1:0] CAP_LUT [16] = '{
        8'h40, 8'h50, 8'h5E, 8'h6A, 8'h74, 8'h7C, 8'h80, 8'h80,
        8'h7C, 8'h74, 8'h6A, 8'h5E, 8'h50, 8'h40, 8'h2E, 8'h1A};

    logic [NSYNC-1:0] sync1_r, sync2_r;
    logic             osc_d_r, vcc_d_r, pin_d_r;
    logic             osc_s, vcc_ok, vcc_gt_bat, bat_ok, pin_s;
    logic [3:0]       ctrl_r;
    logic [`TPS_AGE_W-1:0]  aging_r;
    logic [`TPS_TEMP_W-1:0] temp_r;
    logic             temp_seen_r;
    tps_osc_state_t   osc_st_r;
    tps_conv_state_t  cv_st_r;
    logic [31:0]      pre_r;
    logic [`TPS_SEC_W-1:0] sec_r;
    logic             sec_tick, osc_run, start_evt, periodic;
    logic             forced_r, sw_conv_r;
    logic [31:0]      hold_r;
    logic             ref_r, aw_sel_r;
    logic             dp_wr_r;
    logic [7:0]       dp_addr_r;
    logic             addr_ph, wr_ctrl, wr_aging;

    // The oscillator, supply, battery and reset pin inputs pass two flops before any logic
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sync1_r <= '0;
            sync2_r <= '0;
        end else begin
            sync1_r <= {rst_pin_in, bat_valid_in, vcc_above_bat_in,
                        vcc_above_pf_in, osc_clk_in};
            sync2_r <= sync1_r;
        end
    end
    assign osc_s      = sync2_r[0];
    assign vcc_ok     = sync2_r[1];
    assign vcc_gt_bat = sync2_r[2];
    assign bat_ok     = sync2_r[3];
    assign pin_s      = sync2_r[4];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            osc_d_r <= 1'b0;
            vcc_d_r <= 1'b0;
            pin_d_r <= 1'b1;
        end else begin
            osc_d_r <= osc_s;
            vcc_d_r <= vcc_ok;
            pin_d_r <= pin_s;
        end
    end

    // AHB-Lite slave: zero wait states, always OKAY
    assign addr_ph   = hsel & hready & htrans[1];
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign wr_ctrl   = dp_wr_r & (dp_addr_r == `TPS_ADDR_CTRL);
    assign wr_aging  = dp_wr_r & (dp_addr_r == `TPS_ADDR_AGING);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_wr_r   <= 1'b0;
            dp_addr_r <= 8'h00;
        end else begin
            dp_wr_r   <= addr_ph & hwrite;
            dp_addr_r <= haddr;
        end
    end

    // Read data captured at the address phase so it stands in the data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h00000000;
        end else if (addr_ph && !hwrite) begin
            case (haddr)
                `TPS_ADDR_CTRL:   hrdata <= {28'h0, ctrl_r};
                `TPS_ADDR_AGING:  hrdata <= {24'h0, aging_r};
                `TPS_ADDR_STATUS: hrdata <= {27'h0, rst_pin_oe,
                    cv_st_r == TPS_CV_BUSY, on_backup, osc_run,
                    osc_st_r == TPS_OSC_RUN};
                `TPS_ADDR_TEMP:   hrdata <= {22'h0, temp_r};
                `TPS_ADDR_CAP:    hrdata <= {24'h0, cap_sel};
                default:          hrdata <= 32'h00000000;
            endcase
        end
    end

    // Conversion request bit clears itself when the conversion is taken
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_r <= `TPS_CTRL_RESET;
        end else if (wr_ctrl) begin
            ctrl_r <= hwdata[3:0];
        end else if (cv_st_r == TPS_CV_BUSY) begin
            ctrl_r[`TPS_CTRL_CONV] <= 1'b0;
        end
    end

    // Trim write only stores; it reaches the oscillator at the next load
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            aging_r <= '0;
        end else if (wr_aging) begin
            aging_r <= hwdata[`TPS_AGE_W-1:0];
        end
    end

    assign on_backup = !vcc_ok && !vcc_gt_bat;
    assign start_evt = (vcc_ok & ~vcc_d_r) | (addr_write_ok & on_backup)
                     | (vcc_ok & osc_st_r == TPS_OSC_WAIT);
    assign osc_run   = osc_st_r != TPS_OSC_WAIT
                     && !ctrl_r[`TPS_CTRL_STOP];
    assign osc_enable = osc_run;

    // Oscillator start sequence; battery alone does not start it
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            osc_st_r <= TPS_OSC_WAIT;
        end else if (!vcc_ok && !bat_ok) begin
            osc_st_r <= TPS_OSC_WAIT;
        end else begin
            case (osc_st_r)
                TPS_OSC_WAIT: if (start_evt) begin
                    osc_st_r <= TPS_OSC_WARM;
                end
                TPS_OSC_WARM: if (sec_tick &&
                        sec_r == `TPS_SEC_W'(`TPS_WARM_S - 1)) begin
                    osc_st_r <= TPS_OSC_RUN;
                end
                TPS_OSC_RUN:  osc_st_r <= TPS_OSC_RUN;
                default:      osc_st_r <= TPS_OSC_WAIT;
            endcase
        end
    end

    // Default calendar is loaded by the time keeper on this pulse
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            time_date_load <= 1'b0;
        end else begin
            time_date_load <= osc_st_r == TPS_OSC_WAIT && start_evt
                && !(!vcc_ok && !bat_ok);
        end
    end
    assign time_date_init = {`TPS_INIT_MONTH, `TPS_INIT_DATE,
        `TPS_INIT_YEAR, `TPS_INIT_DAY, `TPS_INIT_HMS};

    // Seconds from oscillator edges; frozen while stopped
    assign sec_tick = osc_run && osc_s && !osc_d_r
                   && pre_r == 32'(OSC_HZ - 1);
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pre_r <= '0;
            sec_r <= '0;
        end else if (osc_st_r == TPS_OSC_WAIT
                     || (osc_st_r == TPS_OSC_WARM && sec_tick
                         && sec_r == `TPS_SEC_W'(`TPS_WARM_S - 1))) begin
            pre_r <= '0;
            sec_r <= '0;
        end else if (osc_run && osc_s && !osc_d_r) begin
            pre_r <= sec_tick ? 32'h0 : pre_r + 32'h1;
            if (sec_tick) begin
                sec_r <= sec_r + 1'b1;
            end
        end
    end
    assign periodic = osc_st_r == TPS_OSC_RUN && sec_tick
                   && sec_r == `TPS_SEC_W'(`TPS_CONV_S - 1);

    // Conversion sequencer; one request outstanding at a time
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cv_st_r    <= TPS_CV_IDLE;
            conv_start <= 1'b0;
            forced_r   <= 1'b0;
            sw_conv_r  <= 1'b0;
        end else begin
            conv_start <= 1'b0;
            case (cv_st_r)
                TPS_CV_IDLE: begin
                    if (osc_st_r == TPS_OSC_WARM && sec_tick
                        && sec_r == `TPS_SEC_W'(`TPS_WARM_S - 1)) begin
                        conv_start <= 1'b1;
                        forced_r   <= 1'b1;
                        cv_st_r    <= TPS_CV_BUSY;
                    end else if (ctrl_r[`TPS_CTRL_CONV]) begin
                        conv_start <= 1'b1;
                        forced_r   <= 1'b1;
                        sw_conv_r  <= 1'b1;
                        cv_st_r    <= TPS_CV_BUSY;
                    end else if (periodic) begin
                        conv_start <= 1'b1;
                        forced_r   <= 1'b0;
                        cv_st_r    <= TPS_CV_BUSY;
                    end
                end
                TPS_CV_BUSY: if (temp_valid) begin
                    sw_conv_r <= 1'b0;
                    cv_st_r   <= TPS_CV_IDLE;
                end
                default: cv_st_r <= TPS_CV_IDLE;
            endcase
        end
    end

    function automatic logic [`TPS_CAP_W-1:0] cap_calc(
        input logic [`TPS_TEMP_W-1:0] t,
        input logic [`TPS_AGE_W-1:0]  aging_trim_value);
        logic signed [`TPS_CAP_W+1:0] s;
        s = $signed({2'b00, CAP_LUT[t[`TPS_TEMP_W-1 -: 4]]})
          + $signed({{2{aging_trim_value[`TPS_AGE_W-1]}}, aging_trim_value});
        if (s < 0) begin
            cap_calc = '0;
        end else if (s > $signed({2'b00, `TPS_CAP_MAX})) begin
            cap_calc = `TPS_CAP_MAX;
        end else begin
            cap_calc = s[`TPS_CAP_W-1:0];
        end
    endfunction
    // Capacitance reload only on new temperature or a forced conversion
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            temp_r      <= '0;
            temp_seen_r <= 1'b0;
            cap_sel     <= '0;
        end else if (cv_st_r == TPS_CV_BUSY && temp_valid) begin
            temp_r      <= temp_data;
            temp_seen_r <= 1'b1;
            if (forced_r || !temp_seen_r || temp_data != temp_r) begin
                cap_sel <= cap_calc(temp_data, aging_r);
            end
        end
    end
    // Reset pin: power-fail low, recovery hold if the oscillator runs, pushbutton hold
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hold_r <= '0;
        end else if (!vcc_ok) begin
            hold_r <= '0;
        end else if (!vcc_d_r) begin
            hold_r <= osc_run ? 32'(REC_CYC) : 32'h0;
        end else if (hold_r == 32'h0 && !pin_s && pin_d_r) begin
            hold_r <= 32'(PB_HOLD_CYC);
        end else if (hold_r != 32'h0) begin
            hold_r <= hold_r - 32'h1;
        end
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rst_pin_oe <= 1'b1;
        end else begin
            rst_pin_oe <= !vcc_ok || hold_r != 32'h0
                || (!vcc_d_r && osc_run);
        end
    end
    assign rst_pin_out = 1'b0;
    // Shared pin picks one source so both can never drive at once
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            aw_sel_r <= 1'b0;
        end else if (ctrl_r[`TPS_CTRL_INTSEL]) begin
            aw_sel_r <= alarm_req;
        end else begin
            aw_sel_r <= !square_wave;
        end
    end
    assign alarm_or_square_wave_oe = aw_sel_r;
    // Open drain: pull low during the low half of the oscillator
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ref_r <= 1'b0;
        end else begin
            ref_r <= ctrl_r[`TPS_CTRL_REFEN] && osc_run && !osc_s;
        end
    end
    assign reference_clock_oe = ref_r;
endmodule

// ==== testbench/tps_sensor_model.sv ====
// Temperature sensor stand-in answering each conversion request
`timescale 1ns/100ps
module tps_sensor_model #(
    parameter int LAT = 12
) (
    input  wire logic       hclk,
    input  wire logic       hresetn,
    input  wire logic       conv_start,
    input  wire logic [9:0] temp_set,
    output logic            temp_valid,
    output logic [9:0]      temp_data
);
    int cnt;
    // Data off the valid pulse is scrambled so nothing leans on it
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt        <= 0;
            temp_valid <= 1'b0;
            temp_data  <= 10'h000;
        end else begin
            temp_valid <= (cnt == 1);
            temp_data  <= (cnt == 1) ? temp_set : ~temp_data;
            if (conv_start)
                cnt <= LAT;
            else if (cnt > 0)
                cnt <= cnt - 1;
        end
    end
endmodule

// ==== testbench/tps_top_assertions.sv ====
// Port-level checks for the power sequencing block
`timescale 1ns/100ps
module tps_top_assertions (
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic        vcc_above_pf_in,
    input wire logic        vcc_above_bat_in,
    input wire logic        temp_valid,
    input wire logic        conv_start,
    input wire logic        osc_enable,
    input wire logic        on_backup,
    input wire logic [7:0]  cap_sel,
    input wire logic        time_date_load,
    input wire logic [55:0] time_date_init,
    input wire logic        rst_pin_oe,
    input wire logic        rst_pin_out
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    AST_BUS_OKAY: assert property (hreadyout && !hresp)
        else $error("bus answer not zero-wait OKAY");
    AST_BACKUP: assert property (
        (!vcc_above_pf_in && !vcc_above_bat_in)[*5] |-> on_backup)
        else $error("backup not selected with primary low");
    AST_PRIMARY: assert property (
        (vcc_above_pf_in || vcc_above_bat_in)[*5] |-> !on_backup)
        else $error("backup selected while primary usable");
    AST_CONV_RUN: assert property (conv_start |-> osc_enable)
        else $error("conversion started with oscillator stopped");
    AST_CONV_PULSE: assert property (conv_start |=> (!conv_start)[*2])
        else $error("conversion requests too close");
    AST_TD_INIT: assert property (time_date_load |->
        (time_date_init == 56'h01010001000000) ##1 !time_date_load)
        else $error("calendar default wrong or load too long");
    AST_PF_RST: assert property (
        (!vcc_above_pf_in)[*4] |-> rst_pin_oe)
        else $error("reset pin not driven on power fail");
    AST_OPEN_DRAIN: assert property (rst_pin_oe |-> !rst_pin_out)
        else $error("reset pin driven high");
    AST_CAP_HOLD: assert property (!$stable(cap_sel) |->
        ($past(temp_valid) || $past(temp_valid, 2)))
        else $error("capacitance changed without a conversion");
endmodule

bind tps_top tps_top_assertions u_chk (.*);

// ==== testbench/tps_top_bench.sv ====
// Self-checking bench for the power sequencing block
`timescale 1ns/100ps
module tps_top_bench;
    logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
    logic [7:0]  haddr, cap_sel, cap0;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [31:0] hwdata, hrdata, rd;
    logic        osc_clk_in, vcc_above_pf_in, vcc_above_bat_in;
    logic        bat_valid_in, addr_write_ok, temp_valid, alarm_req;
    logic        square_wave, conv_start, osc_enable, on_backup, p;
    logic        time_date_load, rst_pin_oe, rst_pin_out, pb_n;
    logic        alarm_or_square_wave_oe, reference_clock_oe;
    logic [9:0]  temp_data, temp_set;
    logic [55:0] time_date_init;
    wire         hready = hreadyout;
    wire         rst_pin_in = pb_n & !rst_pin_oe;
    int          fail_count, num_checks, n, k;

    tps_top #(.OSC_HZ(4), .REC_CYC(20), .PB_HOLD_CYC(10)) dut (.*);
    tps_sensor_model sensor (.*);

    always #2.5 hclk = ~hclk;
    // Oscillator edges held 0.5 ns after a bus clock rising edge
    initial begin
        osc_clk_in = 1'b0;
        #13;
        forever #40 osc_clk_in = ~osc_clk_in;
    end

    task stop_test;
        if (fail_count == 0 && num_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task chk(input logic [63:0] got, input logic [63:0] exp);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    function logic pick(input int s);
        case (s)
            0: pick = conv_start;
            1: pick = time_date_load;
            default: pick = hreadyout;
        endcase
    endfunction

    // Edges until the chosen output is high; running out ends the run
    task wait_on(input int s, input int lim);
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (pick(s) !== 1'b1 && n < lim);
        if (pick(s) !== 1'b1) begin
            fail_count++;
            stop_test();
        end
    endtask

    task cyc(input int c);
        repeat (c) @(posedge hclk);
    endtask

    task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        haddr  <= a;
        hwrite <= w;
        wait_on(2, 20);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        wait_on(2, 20);
        rd = hrdata;
    endtask

    task t_power_up;
        wait_on(1, 20);
        chk(time_date_init, 56'h01010001000000);
        wait_on(0, 300);
        chk(n > 100 && n < 160, 1'b1);
        cyc(16);
        bus(0, 8'h00, 32'h0);
        chk(rd, 32'h2);
        bus(1, 8'h14, 32'hFFFFFFFF);
        bus(0, 8'h14, 32'h0);
        chk(rd, 32'h0);
    endtask

    task t_trim;
        cap0 = cap_sel;
        bus(1, 8'h04, 32'h3);
        cyc(20);
        chk(cap_sel, cap0);
        bus(1, 8'h00, 32'h6);
        wait_on(0, 20);
        cyc(16);
        chk(cap_sel, cap0 + 8'h03);
        wait_on(0, 4200);
        wait_on(0, 4200);
        chk(n > 4070 && n < 4120, 1'b1);
    endtask

    task t_supply;
        vcc_above_pf_in  <= 1'b0;
        vcc_above_bat_in <= 1'b0;
        cyc(8);
        chk({on_backup, rst_pin_oe, osc_enable}, 3'h7);
        vcc_above_bat_in <= 1'b1;
        cyc(8);
        chk(on_backup, 1'b0);
        vcc_above_pf_in <= 1'b1;
        // Pin must stay driven through the hand-over to the recovery hold
        k = 0;
        repeat (10) begin
            @(posedge hclk);
            k += !rst_pin_oe;
        end
        chk(k, 0);
        cyc(25);
        chk(rst_pin_oe, 1'b0);
    endtask

    task t_stop;
        bus(1, 8'h00, 32'h3);
        cyc(4);
        chk(osc_enable, 1'b0);
        k = 0;
        repeat (4500) begin
            @(posedge hclk);
            k += conv_start;
        end
        chk(k, 0);
        vcc_above_pf_in <= 1'b0;
        cyc(8);
        vcc_above_pf_in <= 1'b1;
        cyc(8);
        chk(rst_pin_oe, 1'b0);
        bus(0, 8'h04, 32'h0);
        chk(rd, 32'h3);
        bus(1, 8'h00, 32'h2);
    endtask

    task t_pins;
        pb_n <= 1'b0;
        cyc(4);
        pb_n <= 1'b1;
        cyc(2);
        chk(rst_pin_oe, 1'b1);
        cyc(20);
        chk(rst_pin_oe, 1'b0);
        alarm_req <= 1'b1;
        cyc(3);
        chk(alarm_or_square_wave_oe, 1'b1);
        bus(1, 8'h00, 32'h8);
        cyc(3);
        chk(alarm_or_square_wave_oe, 1'b0);
        square_wave <= 1'b0;
        cyc(3);
        chk(alarm_or_square_wave_oe, 1'b1);
        k = 0;
        p = reference_clock_oe;
        repeat (64) begin
            @(posedge hclk);
            k += (reference_clock_oe != p);
            p = reference_clock_oe;
        end
        chk(k >= 6, 1'b1);
    endtask

    task t_backup_start;
        hresetn          <= 1'b0;
        vcc_above_pf_in  <= 1'b0;
        vcc_above_bat_in <= 1'b0;
        cyc(2);
        hresetn <= 1'b1;
        cyc(300);
        chk(osc_enable, 1'b0);
        addr_write_ok <= 1'b1;
        cyc(1);
        addr_write_ok <= 1'b0;
        wait_on(1, 20);
        chk(osc_enable, 1'b1);
        wait_on(0, 300);
        chk(n > 100 && n < 160, 1'b1);
    endtask

    initial begin
        hclk             = 1'b0;
        hresetn          = 1'b0;
        hsel             = 1'b0;
        hwrite           = 1'b0;
        haddr            = 8'h00;
        htrans           = 2'h0;
        hsize            = 3'h2;
        hwdata           = 32'h0;
        vcc_above_pf_in  = 1'b1;
        vcc_above_bat_in = 1'b1;
        bat_valid_in     = 1'b1;
        pb_n             = 1'b1;
        addr_write_ok    = 1'b0;
        alarm_req        = 1'b0;
        square_wave      = 1'b1;
        temp_set         = 10'h155;
        fail_count       = 0;
        num_checks       = 0;
        cyc(2);
        hresetn <= 1'b1;
        t_power_up();
        t_trim();
        t_supply();
        t_stop();
        t_pins();
        t_backup_start();
        stop_test();
    end
endmodule
